/* src/vfi_pkg.sv */
// video format indicator: shared constants, codes, register map and field layout
// assumes: raster figures arrive already measured by the timing extraction logic
package vfi_pkg;

  // register indices as printed, byte address is four times the index
  localparam logic [7:0] REG_IDX_STATUS = 8'h04;
  localparam logic [7:0] REG_IDX_CTRL = 8'h20;
  localparam logic [7:0] ADDR_STATUS = {REG_IDX_STATUS[5:0], 2'h0};
  localparam logic [7:0] ADDR_CTRL = {REG_IDX_CTRL[5:0], 2'h0};

  // status word layout
  localparam int STD_MSB = 14;
  localparam int STD_LSB = 10;
  localparam int CHROMA_MSB = 7;
  localparam int CHROMA_LSB = 4;
  localparam int LUMA_MSB = 3;
  localparam int LUMA_LSB = 0;
  localparam int CTRL_UPD_BIT = 0;
  localparam logic CTRL_UPD_RESET = 1'h1;

  // video standard codes
  localparam logic [4:0] STD_CLEARED = 5'h00;
  localparam logic [4:0] STD_720P24 = 5'h08;
  localparam logic [4:0] STD_720P24_EM = 5'h09;
  localparam logic [4:0] STD_1080I60 = 5'h0A;
  localparam logic [4:0] STD_1080P30 = 5'h0B;
  localparam logic [4:0] STD_1080I50 = 5'h0C;
  localparam logic [4:0] STD_1080P25 = 5'h0D;
  localparam logic [4:0] STD_1080P25_EM = 5'h0E;
  localparam logic [4:0] STD_1080SF25_EM = 5'h0F;
  localparam logic [4:0] STD_1080P24 = 5'h10;
  localparam logic [4:0] STD_1080SF24 = 5'h11;
  localparam logic [4:0] STD_1080P24_EM = 5'h12;
  localparam logic [4:0] STD_1080SF24_EM = 5'h13;
  localparam logic [4:0] STD_1080I50_ALT = 5'h14;
  localparam logic [4:0] STD_1035I60 = 5'h15;
  localparam logic [4:0] STD_525_487 = 5'h16;
  localparam logic [4:0] STD_525_507 = 5'h17;
  localparam logic [4:0] STD_625_576 = 5'h18;
  localparam logic [4:0] STD_525_487_GEN = 5'h19;
  localparam logic [4:0] STD_625_GEN = 5'h1A;
  localparam logic [4:0] STD_525_507_GEN = 5'h1B;
  localparam logic [4:0] STD_RSVD_A = 5'h1C;
  localparam logic [4:0] STD_UNKNOWN_HD = 5'h1D;
  localparam logic [4:0] STD_UNKNOWN_SD = 5'h1E;
  localparam logic [4:0] STD_RSVD_B = 5'h1F;

  // raster figures
  localparam logic [12:0] TS_720_24 = 13'h101D;
  localparam logic [12:0] TS_1080_30 = 13'h0898;
  localparam logic [12:0] TS_1080_25 = 13'h0A50;
  localparam logic [12:0] TS_1080_24 = 13'h0ABE;
  localparam logic [12:0] TS_1080_50_ALT = 13'h0948;
  localparam logic [12:0] TS_525 = 13'h06B4;
  localparam logic [12:0] TS_625 = 13'h06C0;
  localparam logic [11:0] AW_1280 = 12'h500;
  localparam logic [11:0] AW_3600 = 12'hE10;
  localparam logic [11:0] AW_1920 = 12'h780;
  localparam logic [11:0] AW_2304 = 12'h900;
  localparam logic [11:0] AW_2400 = 12'h960;
  localparam logic [11:0] AW_1440 = 12'h5A0;
  localparam logic [10:0] AL_1035 = 11'h40B;
  localparam logic [10:0] AL_487 = 11'h1E7;
  localparam logic [10:0] AL_507 = 11'h1FB;

  // data format codes
  localparam logic [3:0] FMT_LAST_VALID = 4'h8;
  localparam logic [3:0] FMT_UNKNOWN = 4'hF;

endpackage : vfi_pkg

/* src/vfi_std_classify.sv */
// video format indicator: raster figures to 5-bit video standard code
// assumes: inputs are steady while the caller samples the result
module vfi_std_classify (
  input wire logic hd_mode,
  input wire logic scan_progressive,
  input wire logic [12:0] total_samples,
  input wire logic [11:0] active_words,
  input wire logic [10:0] active_lines,
  output logic [4:0] std_code
);

  // lookup by total samples first, then active words, lines and scan type
  always_comb begin
    std_code = hd_mode ? vfi_pkg::STD_UNKNOWN_HD : vfi_pkg::STD_UNKNOWN_SD;
    if (hd_mode) begin
      case (total_samples)
        vfi_pkg::TS_720_24: begin
          if (active_words == vfi_pkg::AW_1280) std_code = vfi_pkg::STD_720P24;
          else if (active_words == vfi_pkg::AW_3600) std_code = vfi_pkg::STD_720P24_EM;
        end
        vfi_pkg::TS_1080_30: begin
          if (active_lines == vfi_pkg::AL_1035) std_code = vfi_pkg::STD_1035I60;
          else if (active_words == vfi_pkg::AW_1920) begin
            std_code = scan_progressive ? vfi_pkg::STD_1080P30 : vfi_pkg::STD_1080I60;
          end
        end
        vfi_pkg::TS_1080_25: begin
          if (active_words == vfi_pkg::AW_1920) begin
            std_code = scan_progressive ? vfi_pkg::STD_1080P25 : vfi_pkg::STD_1080I50;
          end else if (active_words == vfi_pkg::AW_2304) begin
            std_code = scan_progressive ? vfi_pkg::STD_1080P25_EM : vfi_pkg::STD_1080SF25_EM;
          end
        end
        vfi_pkg::TS_1080_24: begin
          if (active_words == vfi_pkg::AW_1920) begin
            std_code = scan_progressive ? vfi_pkg::STD_1080P24 : vfi_pkg::STD_1080SF24;
          end else if (active_words == vfi_pkg::AW_2400) begin
            std_code = scan_progressive ? vfi_pkg::STD_1080P24_EM : vfi_pkg::STD_1080SF24_EM;
          end
        end
        vfi_pkg::TS_1080_50_ALT: begin
          if (active_words == vfi_pkg::AW_1920) std_code = vfi_pkg::STD_1080I50_ALT;
        end
        default: ;
      endcase
    end else begin
      case (total_samples)
        vfi_pkg::TS_525: begin
          if (active_lines == vfi_pkg::AL_487) begin
            if (active_words == vfi_pkg::AW_1440) std_code = vfi_pkg::STD_525_487;
            else std_code = vfi_pkg::STD_525_487_GEN;
          end else if (active_lines == vfi_pkg::AL_507) begin
            if (active_words == vfi_pkg::AW_1440) std_code = vfi_pkg::STD_525_507;
            else std_code = vfi_pkg::STD_525_507_GEN;
          end
        end
        vfi_pkg::TS_625: begin
          if (active_words == vfi_pkg::AW_1440) std_code = vfi_pkg::STD_625_576;
          else std_code = vfi_pkg::STD_625_GEN;
        end
        default: ;
      endcase
    end
  end

endmodule : vfi_std_classify

/* src/vfi_top.sv */
// video format indicator: standard and data format codes behind an APB status register
// assumes: raster and format inputs are synchronous to pclk, valids are one-cycle pulses
// assumes: raster figures are steady in the cycle that raster_valid is high
//
// Notes on behaviour
// - 720-line 24 Hz raster of 4125 samples reports 08h, extended form 09h.
// - 1080 raster 2200 samples: interlaced or segmented 0Ah, progressive 0Bh.
// - 1080 raster 2640 samples, 1920 words: interlaced/segmented 0Ch, progressive 0Dh.
// - extended 25 Hz 1080 raster, 2304 words: progressive 0Eh, segmented 0Fh.
// - 24 Hz 1080 rasters of 2750 samples map to 10h through 13h.
// - 2376-sample 1080 interlaced reports 14h; 1035-line 2200-sample raster reports 15h.
// - 525-line rasters give 16h, 17h, or generic forms 19h and 1Bh.
// - 625-line rasters give 18h for 576-line form, 1Ah for generic.
// - unknown HD reports 1Dh, unknown SD 1Eh; 1Ch and 1Fh never appear.
// - in HD operation luma and chroma format fields carry separate codes.
// - in SD or ASI operation only luma carries a code; chroma is all ones.
// - both format fields are all ones after reset, lock loss or data-through.
// - format codes 0h to 8h pass through as the defined data formats.
// - unknown data format is Fh; codes 9h to Eh are never reported.
// - status holds standard in 14-10, chroma in 7-4, luma in 3-0, read-only.
// - standard code clears to zero on reset, lock loss or bypass low.
module vfi_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic locked,
  input wire logic pass_through_select_n,
  input wire logic data_through_en,
  input wire logic definition_rate_indicator,
  input wire logic raster_valid,
  input wire logic scan_progressive,
  input wire logic [12:0] total_samples,
  input wire logic [11:0] active_words,
  input wire logic [10:0] active_lines,
  input wire logic format_valid,
  input wire logic [3:0] luma_format_in,
  input wire logic [3:0] chroma_format_in,
  output logic [4:0] video_standard_code,
  output logic [3:0] luma_format_code,
  output logic [3:0] chroma_format_code
);

  typedef struct packed {
    logic [4:0] std;
    logic [3:0] luma;
    logic [3:0] chroma;
    logic upd_en;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } vfi_state_s;

  vfi_state_s st;
  vfi_state_s next_st;
  logic [4:0] class_code;
  logic hd_mode;
  logic [31:0] status_word;
  logic std_clear;
  logic fmt_clear;

  // rate indicator is low for high-definition operation
  assign hd_mode = ~definition_rate_indicator;
  // lock loss clears both; bypass clears only the standard, data-through only formats
  assign std_clear = ~locked | ~pass_through_select_n;
  assign fmt_clear = ~locked | data_through_en;

  vfi_std_classify u_classify (
    .hd_mode(hd_mode),
    .scan_progressive(scan_progressive),
    .total_samples(total_samples),
    .active_words(active_words),
    .active_lines(active_lines),
    .std_code(class_code)
  );

  // reserved format codes are folded onto unknown so they never reach software
  function automatic logic [3:0] vfi_fmt_clean(input logic [3:0] code);
    logic [3:0] res;
    res = (code > vfi_pkg::FMT_LAST_VALID) ? vfi_pkg::FMT_UNKNOWN : code;
    return res;
  endfunction : vfi_fmt_clean

  // status word assembly, unused bits read as zero
  always_comb begin
    status_word = '0;
    status_word[vfi_pkg::STD_MSB:vfi_pkg::STD_LSB] = st.std;
    status_word[vfi_pkg::CHROMA_MSB:vfi_pkg::CHROMA_LSB] = st.chroma;
    status_word[vfi_pkg::LUMA_MSB:vfi_pkg::LUMA_LSB] = st.luma;
  end

  // next state: bus slave, standard code and format codes
  always_comb begin
    next_st = st;
    next_st.ready = 1'h0;
    next_st.slverr = 1'h0;
    // read data is snapshotted in the setup cycle so a read never tears
    if (psel && !penable) begin
      next_st.ready = 1'h1;
      case (paddr)
        vfi_pkg::ADDR_STATUS: next_st.rdata = pwrite ? '0 : status_word;
        vfi_pkg::ADDR_CTRL: begin
          next_st.rdata = '0;
          next_st.rdata[vfi_pkg::CTRL_UPD_BIT] = pwrite ? 1'h0 : st.upd_en;
        end
        default: begin
          next_st.rdata = '0;
          next_st.slverr = 1'h1;
        end
      endcase
    end
    // a write lands at the edge that samples pready; status writes are dropped
    if (psel && penable && st.ready && pwrite && (paddr == vfi_pkg::ADDR_CTRL)) begin
      next_st.upd_en = pwdata[vfi_pkg::CTRL_UPD_BIT];
    end
    // standard code: clear wins over a classification in the same cycle
    if (std_clear) begin
      next_st.std = vfi_pkg::STD_CLEARED;
    end else if (raster_valid && st.upd_en) begin
      next_st.std = class_code;
    end
    // format codes
    if (fmt_clear) begin
      next_st.luma = vfi_pkg::FMT_UNKNOWN;
      next_st.chroma = vfi_pkg::FMT_UNKNOWN;
    end else begin
      if (format_valid && st.upd_en) begin
        next_st.luma = vfi_fmt_clean(luma_format_in);
        next_st.chroma = vfi_fmt_clean(chroma_format_in);
      end
      // sd or asi: a single code, chroma forced regardless of update timing
      if (!hd_mode) next_st.chroma = vfi_pkg::FMT_UNKNOWN;
    end
  end

  // one register bank for all state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.std <= vfi_pkg::STD_CLEARED;
      st.luma <= vfi_pkg::FMT_UNKNOWN;
      st.chroma <= vfi_pkg::FMT_UNKNOWN;
      st.upd_en <= vfi_pkg::CTRL_UPD_RESET;
      st.rdata <= '0;
      st.ready <= 1'h0;
      st.slverr <= 1'h0;
    end else begin
      st <= next_st;
    end
  end

  // all outputs straight from the state flops
  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.slverr;
  assign video_standard_code = st.std;
  assign luma_format_code = st.luma;
  assign chroma_format_code = st.chroma;

  // checks on the block's own outputs
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_std_clr;
    std_clear |=> (video_standard_code == vfi_pkg::STD_CLEARED);
  endproperty
  a_std_clr: assert property (p_std_clr)
    else $error("standard code not cleared after lock loss or bypass");

  property p_fmt_clr;
    fmt_clear |=> (luma_format_code == vfi_pkg::FMT_UNKNOWN)
      && (chroma_format_code == vfi_pkg::FMT_UNKNOWN);
  endproperty
  a_fmt_clr: assert property (p_fmt_clr)
    else $error("format codes not all ones after lock loss or data-through");

  property p_sd_chroma;
    (definition_rate_indicator && !fmt_clear) |=> (chroma_format_code == vfi_pkg::FMT_UNKNOWN);
  endproperty
  a_sd_chroma: assert property (p_sd_chroma)
    else $error("chroma format not all ones in sd operation");

  property p_fmt_legal;
    ((luma_format_code <= vfi_pkg::FMT_LAST_VALID) || (luma_format_code == vfi_pkg::FMT_UNKNOWN))
      && ((chroma_format_code <= vfi_pkg::FMT_LAST_VALID)
      || (chroma_format_code == vfi_pkg::FMT_UNKNOWN));
  endproperty
  a_fmt_legal: assert property (p_fmt_legal)
    else $error("reserved data format code reported");

  property p_std_legal;
    (video_standard_code != vfi_pkg::STD_RSVD_A) && (video_standard_code != vfi_pkg::STD_RSVD_B);
  endproperty
  a_std_legal: assert property (p_std_legal)
    else $error("reserved video standard code reported");

  property p_std_hold;
    (!std_clear && !raster_valid) |=> $stable(video_standard_code);
  endproperty
  a_std_hold: assert property (p_std_hold)
    else $error("standard code changed without a classification");

  property p_std_update;
    (!std_clear && raster_valid && st.upd_en) |=> (video_standard_code == $past(class_code));
  endproperty
  a_std_update: assert property (p_std_update)
    else $error("standard code not loaded from the classifier");

  property p_hd_fmt;
    (!fmt_clear && hd_mode && format_valid && st.upd_en
      && (luma_format_in <= vfi_pkg::FMT_LAST_VALID)
      && (chroma_format_in <= vfi_pkg::FMT_LAST_VALID))
      |=> (luma_format_code == $past(luma_format_in))
      && (chroma_format_code == $past(chroma_format_in));
  endproperty
  a_hd_fmt: assert property (p_hd_fmt)
    else $error("hd format codes not passed to their fields");

  property p_status_read;
    (psel && !penable && !pwrite && (paddr == vfi_pkg::ADDR_STATUS))
      |=> pready && (prdata[vfi_pkg::STD_MSB:vfi_pkg::STD_LSB] == $past(video_standard_code))
      && (prdata[vfi_pkg::LUMA_MSB:vfi_pkg::LUMA_LSB] == $past(luma_format_code))
      ##1 !pready;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read returned wrong fields or timing");

  property p_bad_addr;
    (psel && !penable && (paddr != vfi_pkg::ADDR_STATUS) && (paddr != vfi_pkg::ADDR_CTRL))
      |=> pready && pslverr && (prdata == 32'h0000_0000);
  endproperty
  a_bad_addr: assert property (p_bad_addr)
    else $error("unmapped address not answered with an error");

  // every setup cycle is answered in the very next cycle, zero wait states
  property p_ready_setup;
    (psel && !penable) |=> pready;
  endproperty
  a_ready_setup: assert property (p_ready_setup)
    else $error("setup cycle not answered with ready");

  // ready is never raised outside the cycle after a setup
  property p_ready_idle;
    !(psel && !penable) |=> !pready;
  endproperty
  a_ready_idle: assert property (p_ready_idle)
    else $error("ready raised without a setup cycle");

  // an error response always travels with ready
  property p_slverr_ready;
    pslverr |-> pready;
  endproperty
  a_slverr_ready: assert property (p_slverr_ready)
    else $error("error response without ready");

  // read data holds between transfers so a slow master still sees it
  property p_prdata_hold;
    !(psel && !penable) |=> $stable(prdata);
  endproperty
  a_prdata_hold: assert property (p_prdata_hold)
    else $error("read data changed outside a setup cycle");

  // status read also returns the chroma field of the setup cycle
  property p_status_chroma;
    (psel && !penable && !pwrite && (paddr == vfi_pkg::ADDR_STATUS))
      |=> (prdata[vfi_pkg::CHROMA_MSB:vfi_pkg::CHROMA_LSB] == $past(chroma_format_code));
  endproperty
  a_status_chroma: assert property (p_status_chroma)
    else $error("status read returned wrong chroma field");

  // control write lands at the edge that samples ready
  property p_ctrl_write;
    (psel && penable && pready && pwrite && (paddr == vfi_pkg::ADDR_CTRL))
      |=> (st.upd_en == $past(pwdata[vfi_pkg::CTRL_UPD_BIT]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write not stored");

  // control read-back shows the update enable of the setup cycle
  property p_ctrl_read;
    (psel && !penable && !pwrite && (paddr == vfi_pkg::ADDR_CTRL))
      |=> (prdata[vfi_pkg::CTRL_UPD_BIT] == $past(st.upd_en));
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read-back wrong");

  // update enable low freezes the standard code; only a clear may move it
  property p_std_freeze;
    (!std_clear && !st.upd_en) |=> $stable(video_standard_code);
  endproperty
  a_std_freeze: assert property (p_std_freeze)
    else $error("standard code moved while updates are frozen");

  // luma only moves on a clear or an accepted format pulse
  property p_luma_hold;
    (!fmt_clear && !(format_valid && st.upd_en)) |=> $stable(luma_format_code);
  endproperty
  a_luma_hold: assert property (p_luma_hold)
    else $error("luma format moved without a format pulse");

  // a reserved luma code arrives as unknown
  property p_luma_reserved;
    (!fmt_clear && format_valid && st.upd_en && (luma_format_in > vfi_pkg::FMT_LAST_VALID))
      |=> (luma_format_code == vfi_pkg::FMT_UNKNOWN);
  endproperty
  a_luma_reserved: assert property (p_luma_reserved)
    else $error("reserved luma code not folded to unknown");

  // a reserved chroma code arrives as unknown
  property p_chroma_reserved;
    (!fmt_clear && format_valid && st.upd_en && (chroma_format_in > vfi_pkg::FMT_LAST_VALID))
      |=> (chroma_format_code == vfi_pkg::FMT_UNKNOWN);
  endproperty
  a_chroma_reserved: assert property (p_chroma_reserved)
    else $error("reserved chroma code not folded to unknown");

  // in sd or asi operation the single code lands in the luma field
  property p_sd_luma;
    (!fmt_clear && !hd_mode && format_valid && st.upd_en
      && (luma_format_in <= vfi_pkg::FMT_LAST_VALID))
      |=> (luma_format_code == $past(luma_format_in));
  endproperty
  a_sd_luma: assert property (p_sd_luma)
    else $error("sd format code not placed in the luma field");

  // main scenarios
  c_hd_1080: cover property (raster_valid && hd_mode && !std_clear && st.upd_en
    && (class_code == vfi_pkg::STD_1080I60));
  c_sd_525: cover property (raster_valid && !hd_mode && !std_clear && st.upd_en
    && (class_code == vfi_pkg::STD_525_487));
  c_lock_loss: cover property (locked ##1 !locked);
  c_ctrl_write: cover property (psel && penable && pready && pwrite
    && (paddr == vfi_pkg::ADDR_CTRL));
  c_std_freeze: cover property (raster_valid && !st.upd_en && !std_clear);

endmodule : vfi_top

/* verification/tb_vfi_top.sv */
// testbench for the video format indicator: apb status reads and pulsed raster/format inputs
// assumes: apb slave answers within the wait bound, codes settle one cycle after a pulse
module tb_vfi_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic locked, pass_through_select_n, data_through_en, definition_rate_indicator;
  logic raster_valid, scan_progressive, format_valid;
  logic [12:0] total_samples;
  logic [11:0] active_words;
  logic [10:0] active_lines;
  logic [3:0] luma_format_in, chroma_format_in, luma_format_code, chroma_format_code;
  logic [4:0] video_standard_code;
  int n_errors, checked;

  vfi_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .locked(locked), .pass_through_select_n(pass_through_select_n),
    .data_through_en(data_through_en), .definition_rate_indicator(definition_rate_indicator),
    .raster_valid(raster_valid), .scan_progressive(scan_progressive),
    .total_samples(total_samples), .active_words(active_words), .active_lines(active_lines),
    .format_valid(format_valid), .luma_format_in(luma_format_in),
    .chroma_format_in(chroma_format_in), .video_standard_code(video_standard_code),
    .luma_format_code(luma_format_code), .chroma_format_code(chroma_format_code)
  );

  // 125 MHz clock
  initial begin
    pclk = 1'h0;
    forever #4 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error: %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("counts: %0d checks, %0d mismatches", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      n_errors++;
      report_and_stop();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  // expected format code: reserved values collapse to unknown
  function automatic logic [3:0] fx(input logic [3:0] v);
    return (v > 4'h8) ? 4'hF : v;
  endfunction : fx

  // one raster classification pulse, then port and status checks
  task automatic run_std(input logic sd, input logic prog, input logic [12:0] ts,
                         input logic [11:0] aw, input logic [10:0] al, input logic [4:0] exp);
    @(posedge pclk);
    definition_rate_indicator <= sd;
    scan_progressive <= prog;
    total_samples <= ts;
    active_words <= aw;
    active_lines <= al;
    raster_valid <= 1'h1;
    @(posedge pclk);
    raster_valid <= 1'h0;
    @(negedge pclk);
    check("standard code", 32'(video_standard_code), 32'(exp));
    apb(1'h0, vfi_pkg::ADDR_STATUS, 32'h0);
    check("status standard field", 32'(rdat[14:10]), 32'(exp));
  endtask : run_std

  // one format pulse, then port and status checks
  task automatic run_fmt(input logic [3:0] y, input logic [3:0] c, input logic [3:0] ey,
                         input logic [3:0] ec);
    @(posedge pclk);
    luma_format_in <= y;
    chroma_format_in <= c;
    format_valid <= 1'h1;
    @(posedge pclk);
    format_valid <= 1'h0;
    @(negedge pclk);
    check("format codes", 32'({chroma_format_code, luma_format_code}), 32'({ec, ey}));
    apb(1'h0, vfi_pkg::ADDR_STATUS, 32'h0);
    check("status format fields", 32'(rdat[7:0]), 32'({ec, ey}));
  endtask : run_fmt

  // clear inputs take one edge to show
  task automatic settle();
    @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  initial begin
    {presetn, psel, penable, pwrite, raster_valid, format_valid, data_through_en} = 7'h0;
    {locked, pass_through_select_n, scan_progressive, definition_rate_indicator} = 4'h8 | 4'h4;
    paddr = 8'h0;
    pwdata = 32'h0;
    total_samples = 13'h0;
    active_words = 12'h0;
    active_lines = 11'h0;
    luma_format_in = 4'h0;
    chroma_format_in = 4'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    @(negedge pclk);
    check("standard at reset", 32'(video_standard_code), 32'h0);
    check("formats at reset", 32'({chroma_format_code, luma_format_code}), 32'hFF);
    apb(1'h0, vfi_pkg::ADDR_STATUS, 32'h0);
    check("status at reset", rdat, 32'h000000FF);
    apb(1'h0, vfi_pkg::ADDR_CTRL, 32'h0);
    check("control at reset", rdat, 32'h1);
    $display("test reset done");
    // whole standard table, including unknown rasters
    run_std(1'h0, 1'h1, 13'h101D, 12'h500, 11'h2D0, 5'h08);
    run_std(1'h0, 1'h1, 13'h101D, 12'hE10, 11'h2D0, 5'h09);
    run_std(1'h0, 1'h0, 13'h0898, 12'h780, 11'h438, 5'h0A);
    run_std(1'h0, 1'h1, 13'h0898, 12'h780, 11'h438, 5'h0B);
    run_std(1'h0, 1'h0, 13'h0A50, 12'h780, 11'h438, 5'h0C);
    run_std(1'h0, 1'h1, 13'h0A50, 12'h780, 11'h438, 5'h0D);
    run_std(1'h0, 1'h1, 13'h0A50, 12'h900, 11'h438, 5'h0E);
    run_std(1'h0, 1'h0, 13'h0A50, 12'h900, 11'h438, 5'h0F);
    run_std(1'h0, 1'h1, 13'h0ABE, 12'h780, 11'h438, 5'h10);
    run_std(1'h0, 1'h0, 13'h0ABE, 12'h780, 11'h438, 5'h11);
    run_std(1'h0, 1'h1, 13'h0ABE, 12'h960, 11'h438, 5'h12);
    run_std(1'h0, 1'h0, 13'h0ABE, 12'h960, 11'h438, 5'h13);
    run_std(1'h0, 1'h0, 13'h0948, 12'h780, 11'h438, 5'h14);
    run_std(1'h0, 1'h0, 13'h0898, 12'h780, 11'h40B, 5'h15);
    run_std(1'h1, 1'h0, 13'h06B4, 12'h5A0, 11'h1E7, 5'h16);
    run_std(1'h1, 1'h0, 13'h06B4, 12'h5A0, 11'h1FB, 5'h17);
    run_std(1'h1, 1'h0, 13'h06B4, 12'h578, 11'h1E7, 5'h19);
    run_std(1'h1, 1'h0, 13'h06B4, 12'h578, 11'h1FB, 5'h1B);
    run_std(1'h1, 1'h0, 13'h06C0, 12'h5A0, 11'h240, 5'h18);
    run_std(1'h1, 1'h0, 13'h06C0, 12'h578, 11'h240, 5'h1A);
    run_std(1'h0, 1'h1, 13'h101D, 12'h3E8, 11'h2D0, 5'h1D);
    run_std(1'h0, 1'h0, 13'h0948, 12'h500, 11'h438, 5'h1D);
    run_std(1'h0, 1'h0, 13'h0898, 12'h500, 11'h438, 5'h1D);
    run_std(1'h1, 1'h0, 13'h06B4, 12'h5A0, 11'h200, 5'h1E);
    run_std(1'h1, 1'h0, 13'h0898, 12'h780, 11'h438, 5'h1E);
    run_std(1'h0, 1'h0, 13'h0BB8, 12'h780, 11'h438, 5'h1D);
    run_std(1'h1, 1'h0, 13'h03E8, 12'h5A0, 11'h1E7, 5'h1E);
    // figures move without a pulse: code must hold
    total_samples <= 13'h0898;
    repeat (3) settle();
    check("standard held", 32'(video_standard_code), 32'h1E);
    $display("test standards done");
    @(posedge pclk);
    definition_rate_indicator <= 1'h0;
    for (int i = 0; i < 16; i++) run_fmt(4'(i), 4'(15 - i), fx(4'(i)), fx(4'(15 - i)));
    @(posedge pclk);
    definition_rate_indicator <= 1'h1;
    for (int i = 0; i < 16; i++) run_fmt(4'(i), 4'(15 - i), fx(4'(i)), 4'hF);
    $display("test formats done");
    // update enable freezes the codes
    @(posedge pclk);
    definition_rate_indicator <= 1'h0;
    run_std(1'h0, 1'h0, 13'h0898, 12'h780, 11'h438, 5'h0A);
    run_fmt(4'h6, 4'h5, 4'h6, 4'h5);
    apb(1'h1, vfi_pkg::ADDR_CTRL, 32'h0);
    apb(1'h0, vfi_pkg::ADDR_CTRL, 32'h0);
    check("control cleared", rdat, 32'h0);
    run_std(1'h0, 1'h1, 13'h0898, 12'h780, 11'h438, 5'h0A);
    run_fmt(4'h2, 4'h3, 4'h6, 4'h5);
    apb(1'h1, vfi_pkg::ADDR_CTRL, 32'h1);
    run_std(1'h0, 1'h1, 13'h0898, 12'h780, 11'h438, 5'h0B);
    apb(1'h1, vfi_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    check("status write error", 32'(rerr), 32'h0);
    apb(1'h0, vfi_pkg::ADDR_STATUS, 32'h0);
    check("status after write", rdat, 32'h00002C56);
    apb(1'h0, 8'h40, 32'h0);
    check("unmapped error", 32'(rerr), 32'h1);
    check("unmapped data", rdat, 32'h0);
    $display("test registers done");
    // lock loss, bypass and data-through clears
    @(posedge pclk);
    locked <= 1'h0;
    settle();
    check("lock loss clear", 32'({video_standard_code, chroma_format_code, luma_format_code}),
          32'h0FF);
    run_std(1'h0, 1'h0, 13'h0898, 12'h780, 11'h438, 5'h00);
    @(posedge pclk);
    locked <= 1'h1;
    run_std(1'h0, 1'h0, 13'h0898, 12'h780, 11'h438, 5'h0A);
    run_fmt(4'h6, 4'h5, 4'h6, 4'h5);
    @(posedge pclk);
    pass_through_select_n <= 1'h0;
    settle();
    check("bypass clear", 32'({video_standard_code, chroma_format_code, luma_format_code}),
          32'h056);
    run_std(1'h0, 1'h0, 13'h0898, 12'h780, 11'h438, 5'h00);
    @(posedge pclk);
    pass_through_select_n <= 1'h1;
    run_std(1'h0, 1'h0, 13'h0898, 12'h780, 11'h438, 5'h0A);
    @(posedge pclk);
    data_through_en <= 1'h1;
    settle();
    check("data-through", 32'({video_standard_code, chroma_format_code, luma_format_code}),
          32'hAFF);
    run_fmt(4'h6, 4'h5, 4'hF, 4'hF);
    $display("test clears done");
    report_and_stop();
  end
endmodule : tb_vfi_top
